// [tb/cell_meter.sv]
// measurement path model feeding current and voltage
`timescale 1ns/1ps
module cell_meter (
    input wire logic hclk,
    input wire logic signed [15:0] set_ma,
    output logic signed [15:0] average_current_a,
    output logic [23:0] cell_voltage_uv
);
    assign cell_voltage_uv = 24'h3D0900;
    // averaged current follows the load one edge later
    always @(posedge hclk) average_current_a <= set_ma;
endmodule // cell_meter

// [tb/current_mode_detector_bench.sv]
// self-checking bench for the current-mode detector
`timescale 1ns/1ps
module current_mode_detector_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic learn_valid = 1'b0, hreadyout, hresp, imax_irq_pin, dsg_flag;
    logic ce = 1'b1;
    logic chg_flow_flag, relax_flag, ocv_take, ir_apply;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic signed [15:0] set_ma = 16'h0000, imax_estimate = 16'h0000;
    logic signed [15:0] average_current_a;
    logic [15:0] learn_capacity = 16'h0, ir_correction_limit, cell_chem_capacity;
    logic [23:0] cell_voltage_uv, ocv_uv;
    int errors = 0, checked = 0, cycles = 0, pulses = 0;
    cell_meter i_cell_meter (.hclk, .set_ma, .average_current_a,
        .cell_voltage_uv);
    current_mode_detector #(.TICK_PERIOD(20)) i_current_mode_detector (
        .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
        .average_current_a, .cell_voltage_uv, .imax_estimate, .learn_valid,
        .learn_capacity, .imax_irq_pin, .dsg_flag, .chg_flow_flag,
        .relax_flag, .ocv_take, .ocv_uv, .ir_apply, .ir_correction_limit,
        .cell_chem_capacity);
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] a[9] = '{32'h1C0, 32'h0, 32'h8, 32'h10, 32'h18, 32'h20,
            32'h24, 32'h28, 32'h100};
        logic [31:0] e[9] = '{32'h1F4, 32'h3C, 32'h4B, 32'h28, 32'h3C, 32'h3C,
            32'h1, 32'h190, 32'h3E8};
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, a[i], 32'h0);
            chk("reset value", rd, e[i]);
        end
        chk("ir limit port", ir_correction_limit, 32'h190);
        bus(1'b0, 32'h200, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, 32'h18, 32'hFFFF);
        bus(1'b0, 32'h18, 32'h0);
        chk("dsg rest full", rd, 32'hFFFF);
        bus(1'b1, 32'h20, 32'h1FF);
        bus(1'b0, 32'h20, 32'h0);
        chk("chg rest width", rd, 32'hFF);
        bus(1'b1, 32'h18, 32'h3);
        bus(1'b1, 32'h20, 32'h2);
        bus(1'b1, 32'h24, 32'h2);
        $display("test registers done");
    endtask
    // band 40 stays under both levels
    task automatic t_modes;
        set_ma <= 16'h00C8;
        cyc(5);
        chk("ir apply wake", ir_apply, 1'b1);
        set_ma <= 16'hFF9C;
        cyc(5);
        chk("dsg set", dsg_flag, 1'b1);
        chk("chg clear", chg_flow_flag, 1'b0);
        set_ma <= 16'hFFCE;
        cyc(3);
        chk("dsg above level", dsg_flag, 1'b0);
        set_ma <= 16'h0000;
        cyc(30);
        set_ma <= 16'hFFCE;
        cyc(3);
        set_ma <= 16'h0000;
        cyc(30);
        chk("dsg rest restart", relax_flag, 1'b0);
        cyc(45);
        chk("dsg rest entry", relax_flag, 1'b1);
        set_ma <= 16'h00C8;
        cyc(15);
        chk("rest holds", relax_flag, 1'b1);
        cyc(45);
        chk("rest exit", relax_flag, 1'b0);
        chk("ir apply after rest", ir_apply, 1'b0);
        set_ma <= 16'h0000;
        cyc(15);
        chk("chg rest early", relax_flag, 1'b0);
        cyc(45);
        chk("chg rest entry", relax_flag, 1'b1);
        $display("test modes done");
    endtask
    task automatic t_imax_learn;
        int p = pulses;
        imax_estimate <= 16'h0190;
        cyc(5);
        chk("no irq small", pulses, p);
        imax_estimate <= 16'h0258;
        cyc(5);
        chk("irq on step", pulses, p + 1);
        bus(1'b1, 32'h1C0, 32'hFED4);
        imax_estimate <= 16'h00FA;
        cyc(5);
        chk("irq negative step", pulses, p + 2);
        bus(1'b0, 32'h108, 32'h0);
        chk("imax last", rd, 32'hFA);
        learn_capacity <= 16'h1234;
        learn_valid <= 1'b1;
        cyc(1);
        learn_valid <= 1'b0;
        cyc(2);
        chk("learned port", cell_chem_capacity, 32'h1234);
        bus(1'b0, 32'h100, 32'h0);
        chk("learned reg", rd, 32'h1234);
        $display("test imax and learn done");
    endtask
    task automatic t_ocv;
        int n = 0;
        int p = pulses;
        while (ocv_take !== 1'b1 && n < 40000) begin
            cyc(1);
            n++;
        end
        chk("ocv pulse", ocv_take, 1'b1);
        chk("ocv voltage", ocv_uv, 32'h3D0900);
        bus(1'b0, 32'h104, 32'h0);
        chk("status rest", rd, 32'h200C);
        chk("okay response", hresp, 1'b0);
        ce <= 1'b0;
        imax_estimate <= 16'h0500;
        cyc(3);
        chk("ce stall ready", hreadyout, 1'b0);
        chk("ce freezes irq", pulses, p);
        ce <= 1'b1;
        cyc(3);
        chk("irq after ce", pulses, p + 1);
        $display("test ocv and enable done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (imax_irq_pin === 1'b1) pulses++;
        if (cycles == 50000) begin
            errors++;
            complete_run;
        end
    end
    initial begin
        cyc(5);
        hresetn <= 1'b1;
        cyc(1);
        t_regs;
        t_modes;
        t_imax_learn;
        t_ocv;
        complete_run;
    end
endmodule // current_mode_detector_bench

// [tb/detector_assertions.sv]
// port checker for the current-mode detector
`timescale 1ns/1ps
module detector_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hreadyout,
    input wire logic signed [15:0] average_current_a,
    input wire logic imax_irq_pin,
    input wire logic dsg_flag,
    input wire logic chg_flow_flag,
    input wire logic relax_flag,
    input wire logic ocv_take,
    input wire logic ir_apply
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////////
    dsg_cause_a: assert property (
        dsg_flag && $past(ce) |-> $past(average_current_a) < 0)
        else $error("dsg flag without discharge current");
    chg_cause_a: assert property (
        chg_flow_flag && $past(ce) |-> $past(average_current_a) > 0)
        else $error("charge flag without charge current");
    flags_apart_a: assert property (!(dsg_flag && chg_flow_flag))
        else $error("charge and discharge flags together");
    ocv_single_a: assert property (ocv_take |=> !ocv_take)
        else $error("ocv pulse too long");
    ocv_rest_a: assert property (ocv_take |-> relax_flag)
        else $error("ocv taken outside rest");
    rest_exit_a: assert property (
        $fell(relax_flag) |-> dsg_flag || chg_flow_flag)
        else $error("rest left without flow");
    rest_entry_a: assert property (
        $rose(relax_flag) |-> !dsg_flag && !chg_flow_flag)
        else $error("rest entered during flow");
    ir_apply_a: assert property (
        ir_apply |-> chg_flow_flag && !relax_flag)
        else $error("ir correction offered wrongly");
    bus_ready_a: assert property (hreadyout == ce)
        else $error("hreadyout differs from ce");
    cover property ($rose(relax_flag));
    cover property ($fell(relax_flag));
    cover property (imax_irq_pin);
    cover property (ocv_take);
endmodule // detector_assertions
bind current_mode_detector detector_assertions i_detector_assertions (
    .hclk, .hresetn, .ce, .hreadyout, .average_current_a, .imax_irq_pin,
    .dsg_flag, .chg_flow_flag, .relax_flag, .ocv_take, .ir_apply);

// [verilog/current_mode_detector.sv]
// charge, discharge and rest detection with register file
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module current_mode_detector #(
    parameter int unsigned TICK_PERIOD = detector_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic signed [15:0] average_current_a,
    input wire logic [23:0] cell_voltage_uv,
    input wire logic signed [15:0] imax_estimate,
    input wire logic learn_valid,
    input wire logic [15:0] learn_capacity,
    output logic imax_irq_pin,
    output logic dsg_flag,
    output logic chg_flow_flag,
    output logic relax_flag,
    output logic ocv_take,
    output logic [23:0] ocv_uv,
    output logic ir_apply,
    output logic [15:0] ir_correction_limit,
    output logic [15:0] cell_chem_capacity
);

    ////////////////////////////////////////////////////////////////////////////
    // shared tick
    logic tick;

    second_tick #(.PERIOD(TICK_PERIOD)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tick(tick)
    );

    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave
    detector_pkg::cfg_t cfg_reg;
    detector_pkg::cfg_t cfg_next;
    logic [15:0] cap_reg;
    logic [15:0] cap_next;
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_idx_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic addr_ok;
    logic [31:0] status_word;
    logic signed [15:0] imax_last_reg;
    logic signed [15:0] imax_last_next;
    logic [23:0] ocv_reg;
    logic [23:0] ocv_next;

    assign addr_ok = hsel & htrans[1] & hready;

    always_comb begin
        wr_pend_next = 1'b0;
        wr_idx_next = wr_idx_reg;
        rdata_next = rdata_reg;
        if (addr_ok) begin
            wr_pend_next = hwrite;
            wr_idx_next = reg_index(haddr);
            if (!hwrite) begin
                case (reg_index(haddr))
                    detector_pkg::IDX_IMAX_STEP:
                        rdata_next = {16'h0000, cfg_reg.imax_step};
                    detector_pkg::IDX_DSG_LEVEL:
                        rdata_next = {16'h0000, cfg_reg.dsg_level};
                    detector_pkg::IDX_CHG_LEVEL:
                        rdata_next = {16'h0000, cfg_reg.chg_level};
                    detector_pkg::IDX_BAND:
                        rdata_next = {16'h0000, cfg_reg.band};
                    detector_pkg::IDX_DSG_REST:
                        rdata_next = {16'h0000, cfg_reg.dsg_rest};
                    detector_pkg::IDX_CHG_REST:
                        rdata_next = {24'h000000, cfg_reg.chg_rest};
                    detector_pkg::IDX_EXIT:
                        rdata_next = {24'h000000, cfg_reg.exit_delay};
                    detector_pkg::IDX_IR_LIMIT:
                        rdata_next = {16'h0000, cfg_reg.ir_limit};
                    detector_pkg::IDX_CHEM_CAP:
                        rdata_next = {16'h0000, cap_reg};
                    detector_pkg::IDX_STATUS: rdata_next = status_word;
                    detector_pkg::IDX_IMAX_LAST:
                        rdata_next = {16'h0000, imax_last_reg};
                    detector_pkg::IDX_OCV: rdata_next = {8'h00, ocv_reg};
                    default: rdata_next = 32'h00000000;
                endcase
            end
        end
    end

    // configuration writes in the data phase
    always_comb begin
        cfg_next = cfg_reg;
        cap_next = cap_reg;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                detector_pkg::IDX_IMAX_STEP: cfg_next.imax_step = hwdata[15:0];
                detector_pkg::IDX_DSG_LEVEL: cfg_next.dsg_level = hwdata[15:0];
                detector_pkg::IDX_CHG_LEVEL: cfg_next.chg_level = hwdata[15:0];
                detector_pkg::IDX_BAND: cfg_next.band = hwdata[15:0];
                detector_pkg::IDX_DSG_REST: cfg_next.dsg_rest = hwdata[15:0];
                detector_pkg::IDX_CHG_REST: cfg_next.chg_rest = hwdata[7:0];
                detector_pkg::IDX_EXIT: cfg_next.exit_delay = hwdata[7:0];
                detector_pkg::IDX_IR_LIMIT: cfg_next.ir_limit = hwdata[15:0];
                detector_pkg::IDX_CHEM_CAP: cap_next = hwdata[15:0];
                default: cfg_next = cfg_reg;
            endcase
        end
        if (learn_valid) begin
            cap_next = learn_capacity;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            rdata_reg <= 32'h00000000;
            cfg_reg.imax_step <= detector_pkg::RST_IMAX_STEP;
            cfg_reg.dsg_level <= detector_pkg::RST_DSG_LEVEL;
            cfg_reg.chg_level <= detector_pkg::RST_CHG_LEVEL;
            cfg_reg.band <= detector_pkg::RST_BAND;
            cfg_reg.dsg_rest <= detector_pkg::RST_DSG_REST;
            cfg_reg.chg_rest <= detector_pkg::RST_CHG_REST;
            cfg_reg.exit_delay <= detector_pkg::RST_EXIT;
            cfg_reg.ir_limit <= detector_pkg::RST_IR_LIMIT;
            cap_reg <= detector_pkg::RST_CHEM_CAP;
        end else if (ce) begin
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            rdata_reg <= rdata_next;
            cfg_reg <= cfg_next;
            cap_reg <= cap_next;
        end
    end

    assign hreadyout = ce;
    assign hrdata = rdata_reg;
    assign hresp = 1'b0;
    assign ir_correction_limit = cfg_reg.ir_limit;
    assign cell_chem_capacity = cap_reg;

    ////////////////////////////////////////////////////////////////////////////
    // mode machine
    logic signed [16:0] cur;
    logic signed [16:0] band_pos;
    logic signed [16:0] dsg_pos;
    logic signed [16:0] chg_pos;
    logic below_band;
    logic above_band;
    logic dsg_now;
    logic chg_now;
    detector_pkg::mode_t mode_reg;
    detector_pkg::mode_t mode_next;
    logic [15:0] timer_reg;
    logic [15:0] timer_next;
    logic [15:0] timer_inc;
    logic [10:0] rest_reg;
    logic [10:0] rest_next;
    logic [23:0] prev_uv_reg;
    logic [23:0] prev_uv_next;
    logic prev_ok_reg;
    logic prev_ok_next;
    logic ocv_done_reg;
    logic ocv_done_next;
    logic ocv_take_reg;
    logic ocv_take_next;
    logic wake_reg;
    logic wake_next;
    logic dsg_reg;
    logic chg_reg;
    logic signed [24:0] dv;
    logic [24:0] dv_abs;

    assign cur = {average_current_a[15], average_current_a};
    assign band_pos = $signed({1'b0, cfg_reg.band});
    assign dsg_pos = $signed({1'b0, cfg_reg.dsg_level});
    assign chg_pos = $signed({1'b0, cfg_reg.chg_level});
    assign below_band = cur < -band_pos;
    assign above_band = cur > band_pos;
    assign dsg_now = cur < -dsg_pos;
    assign chg_now = cur > chg_pos;
    assign timer_inc = (timer_reg == 16'hFFFF) ? timer_reg
                                               : timer_reg + 16'h0001;
    assign dv = $signed({1'b0, cell_voltage_uv}) - $signed({1'b0, prev_uv_reg});
    assign dv_abs = dv[24] ? 25'(-dv) : 25'(dv);

    always_comb begin
        mode_next = mode_reg;
        timer_next = timer_reg;
        rest_next = rest_reg;
        prev_uv_next = prev_uv_reg;
        prev_ok_next = prev_ok_reg;
        ocv_done_next = ocv_done_reg;
        ocv_take_next = 1'b0;
        ocv_next = ocv_reg;
        wake_next = wake_reg;
        case (mode_reg)
            detector_pkg::MODE_NONE,
            detector_pkg::MODE_DSG_FLOW,
            detector_pkg::MODE_CHG_FLOW: begin
                timer_next = 16'h0000;
                if (below_band) begin
                    mode_next = detector_pkg::MODE_DSG_FLOW;
                end else if (above_band) begin
                    mode_next = detector_pkg::MODE_CHG_FLOW;
                end else if (mode_reg == detector_pkg::MODE_DSG_FLOW) begin
                    mode_next = detector_pkg::MODE_DSG_QUAL;
                end else if (mode_reg == detector_pkg::MODE_CHG_FLOW) begin
                    mode_next = detector_pkg::MODE_CHG_QUAL;
                end
            end
            detector_pkg::MODE_DSG_QUAL,
            detector_pkg::MODE_CHG_QUAL: begin
                if (below_band) begin
                    mode_next = detector_pkg::MODE_DSG_FLOW;
                    timer_next = 16'h0000;
                end else if (above_band) begin
                    mode_next = detector_pkg::MODE_CHG_FLOW;
                    timer_next = 16'h0000;
                end else if ((mode_reg == detector_pkg::MODE_DSG_QUAL &&
                              timer_reg >= cfg_reg.dsg_rest) ||
                             (mode_reg == detector_pkg::MODE_CHG_QUAL &&
                              timer_reg >= {8'h00, cfg_reg.chg_rest})) begin
                    mode_next = detector_pkg::MODE_RELAX;
                    timer_next = 16'h0000;
                    rest_next = 11'h000;
                    prev_ok_next = 1'b0;
                    ocv_done_next = 1'b0;
                    wake_next = 1'b0;
                end else if (tick) begin
                    timer_next = timer_inc;
                end
            end
            detector_pkg::MODE_RELAX: begin
                if (dsg_now || chg_now) begin
                    if (timer_reg >= {8'h00, cfg_reg.exit_delay}) begin
                        mode_next = dsg_now ? detector_pkg::MODE_DSG_FLOW
                                            : detector_pkg::MODE_CHG_FLOW;
                        timer_next = 16'h0000;
                    end else if (tick) begin
                        timer_next = timer_inc;
                    end
                end else begin
                    timer_next = 16'h0000;
                end
                if (tick) begin
                    if (rest_reg != detector_pkg::SETTLE_SECONDS) begin
                        rest_next = rest_reg + 11'h001;
                    end
                    prev_uv_next = cell_voltage_uv;
                    prev_ok_next = 1'b1;
                    if (rest_reg == detector_pkg::SETTLE_SECONDS &&
                        prev_ok_reg && !ocv_done_reg &&
                        dv_abs < detector_pkg::SLOPE_LIMIT_UV) begin
                        ocv_take_next = 1'b1;
                        ocv_done_next = 1'b1;
                        ocv_next = cell_voltage_uv;
                    end
                end
            end
            default: begin
                mode_next = detector_pkg::MODE_NONE;
                timer_next = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_reg <= detector_pkg::MODE_NONE;
            timer_reg <= 16'h0000;
            rest_reg <= 11'h000;
            prev_uv_reg <= 24'h000000;
            prev_ok_reg <= 1'b0;
            ocv_done_reg <= 1'b0;
            ocv_take_reg <= 1'b0;
            ocv_reg <= 24'h000000;
            wake_reg <= 1'b1;
            dsg_reg <= 1'b0;
            chg_reg <= 1'b0;
        end else if (ce) begin
            mode_reg <= mode_next;
            timer_reg <= timer_next;
            rest_reg <= rest_next;
            prev_uv_reg <= prev_uv_next;
            prev_ok_reg <= prev_ok_next;
            ocv_done_reg <= ocv_done_next;
            ocv_take_reg <= ocv_take_next;
            ocv_reg <= ocv_next;
            wake_reg <= wake_next;
            dsg_reg <= dsg_now;
            chg_reg <= chg_now;
        end
    end

    assign dsg_flag = dsg_reg;
    assign chg_flow_flag = chg_reg;
    assign relax_flag = (mode_reg == detector_pkg::MODE_RELAX);
    assign ocv_take = ocv_take_reg;
    assign ocv_uv = ocv_reg;
    assign ir_apply = wake_reg & chg_reg;

    always_comb begin
        status_word = 32'h00000000;
        status_word[detector_pkg::ST_DSG_BIT] = dsg_reg;
        status_word[detector_pkg::ST_CHG_BIT] = chg_reg;
        status_word[detector_pkg::ST_RELAX_BIT] = relax_flag;
        status_word[detector_pkg::ST_OCV_DONE_BIT] = ocv_done_reg;
        status_word[detector_pkg::ST_WAKE_BIT] = wake_reg;
        status_word[detector_pkg::ST_MODE_LSB +: 6] = mode_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // max-current step interrupt
    logic signed [16:0] imax_diff;
    logic [16:0] diff_abs;
    logic [16:0] step_abs;
    logic irq_reg;
    logic irq_next;

    assign imax_diff = {imax_estimate[15], imax_estimate}
                     - {imax_last_reg[15], imax_last_reg};
    assign diff_abs = imax_diff[16] ? 17'(-imax_diff) : 17'(imax_diff);
    assign step_abs = cfg_reg.imax_step[15]
                    ? 17'(-{cfg_reg.imax_step[15], cfg_reg.imax_step})
                    : {1'b0, cfg_reg.imax_step};

    always_comb begin
        irq_next = 1'b0;
        imax_last_next = imax_last_reg;
        if (imax_diff != 17'h00000 && diff_abs >= step_abs) begin
            irq_next = 1'b1;
            imax_last_next = imax_estimate;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
            imax_last_reg <= 16'h0000;
        end else if (ce) begin
            irq_reg <= irq_next;
            imax_last_reg <= imax_last_next;
        end
    end

    assign imax_irq_pin = irq_reg;
endmodule // current_mode_detector

// [verilog/detector_pkg.sv]
// constants and types shared by the current-mode detector files
package detector_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_IMAX_STEP = 8'h70;
    localparam logic [7:0] IDX_DSG_LEVEL = 8'h00;
    localparam logic [7:0] IDX_CHG_LEVEL = 8'h02;
    localparam logic [7:0] IDX_BAND = 8'h04;
    localparam logic [7:0] IDX_DSG_REST = 8'h06;
    localparam logic [7:0] IDX_CHG_REST = 8'h08;
    localparam logic [7:0] IDX_EXIT = 8'h09;
    localparam logic [7:0] IDX_IR_LIMIT = 8'h0A;
    localparam logic [7:0] IDX_CHEM_CAP = 8'h40;
    localparam logic [7:0] IDX_STATUS = 8'h41;
    localparam logic [7:0] IDX_IMAX_LAST = 8'h42;
    localparam logic [7:0] IDX_OCV = 8'h43;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RST_IMAX_STEP = 16'h01F4;
    localparam logic [15:0] RST_DSG_LEVEL = 16'h003C;
    localparam logic [15:0] RST_CHG_LEVEL = 16'h004B;
    localparam logic [15:0] RST_BAND = 16'h0028;
    localparam logic [15:0] RST_DSG_REST = 16'h003C;
    localparam logic [7:0] RST_CHG_REST = 8'h3C;
    localparam logic [7:0] RST_EXIT = 8'h01;
    localparam logic [15:0] RST_IR_LIMIT = 16'h0190;
    localparam logic [15:0] RST_CHEM_CAP = 16'h03E8;

    ////////////////////////////////////////////////////////////////////////////
    // status word bit positions
    localparam int unsigned ST_DSG_BIT = 0;
    localparam int unsigned ST_CHG_BIT = 1;
    localparam int unsigned ST_RELAX_BIT = 2;
    localparam int unsigned ST_OCV_DONE_BIT = 3;
    localparam int unsigned ST_WAKE_BIT = 4;
    localparam int unsigned ST_MODE_LSB = 8;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SECOND_NS = 1000000000;
    localparam int unsigned TICK_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_MINUTES = 30;
    localparam logic [10:0] SETTLE_SECONDS = 11'(SETTLE_MINUTES * 60);
    localparam logic [24:0] SLOPE_LIMIT_UV = 25'h0000004;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic signed [15:0] imax_step;
        logic [15:0] dsg_level;
        logic [15:0] chg_level;
        logic [15:0] band;
        logic [15:0] dsg_rest;
        logic [7:0] chg_rest;
        logic [7:0] exit_delay;
        logic [15:0] ir_limit;
    } cfg_t;

    typedef enum logic [5:0] {
        MODE_NONE = 6'h01,
        MODE_DSG_FLOW = 6'h02,
        MODE_CHG_FLOW = 6'h04,
        MODE_DSG_QUAL = 6'h08,
        MODE_CHG_QUAL = 6'h10,
        MODE_RELAX = 6'h20
    } mode_t;

endpackage

// [verilog/second_tick.sv]
// one-second tick divider
`timescale 1ns/1ps
module second_tick #(
    parameter int unsigned PERIOD = 100000000
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    output logic tick
);
    localparam int unsigned CW = (PERIOD < 2) ? 1 : $clog2(PERIOD);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = 1'b0;
        count_next = count_reg + CW'(1);
        if (count_reg == CW'(PERIOD - 1)) begin
            count_next = '0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg <= '0;
            tick_reg <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg & ce;
endmodule // second_tick
